/* rtl/crc_top.sv */
// Clock and reset controller: clock source selection, start-up gating, reset collection.
// Assumes oscillators arrive as one-cycle ticks on core_clk and software uses AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "crc_cfg.svh"

module crc_top #(
  parameter logic [12:0] EXT_FAST_STARTUP = `CRC_EXT_FAST_STARTUP,
  parameter logic [12:0] EXT_SLOW_STARTUP = `CRC_EXT_SLOW_STARTUP
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Register bus
  input wire crc_pkg::crc_axil_req_t axil_req,
  output crc_pkg::crc_axil_rsp_t axil_rsp,
  // Oscillator ticks
  input wire logic int_fast_tick,
  input wire logic ext_fast_tick,
  input wire logic pll_tick,
  input wire logic pll_lock,
  input wire logic fabric_local_clock,
  input wire logic ext_slow_tick,
  // Oscillator enables
  output logic int_fast_osc_en,
  output logic ext_fast_osc_en,
  output logic ext_fast_bypass_en,
  output logic pll_en,
  output logic ext_slow_osc_en,
  // Clock outputs
  output logic system_clock_out,
  output logic rtc_clock_out,
  output logic watchdog_clock_out,
  output logic internal_slow_clk,
  // Reset and low-power events
  input wire logic external_reset_pin_n,
  input wire logic window_watchdog_expired,
  input wire logic independent_watchdog_expired,
  input wire logic core_reset_request,
  input wire logic standby_entry_req,
  input wire logic stop_entry_req,
  input wire logic standby_reset_option,
  input wire logic stop_reset_option,
  input wire logic power_detect,
  input wire logic standby_exit,
  input wire logic backup_supply_up,
  input wire logic in_stop,
  input wire logic in_standby,
  // Reset and mode outputs
  output logic sys_reset_out,
  output logic power_reset_out,
  output logic backup_reset_out,
  output logic stop_enter,
  output logic standby_enter
);
  import crc_pkg::*;

  // ****************************************
  // State and helpers
  // ****************************************
  crc_top_st_t st_reg;
  crc_top_st_t st_next;
  logic ext_fast_rdy;
  logic ext_fast_gated;
  logic ext_slow_rdy;
  logic ext_slow_gated;
  logic int_fast_gated;
  logic pll_rdy;
  logic lp_rst;
  logic sys_evt;
  logic pwr_evt;
  logic bd_evt;
  logic clocks_halted;

  function automatic logic crc_mapped(input logic [7:0] addr);
    return addr == `CRC_OFS_CLK_CTRL || addr == `CRC_OFS_CLK_CFG ||
           addr == `CRC_OFS_BACKUP || addr == `CRC_OFS_RST_CAUSE ||
           addr == `CRC_OFS_PWR_CTRL;
  endfunction

  // Plain readback of the register at addr
  function automatic logic [31:0] crc_read(input logic [7:0] addr);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (addr)
      `CRC_OFS_CLK_CTRL: begin
        v[`CRC_CC_INT_FAST_ON] = st_reg.int_fast_on;
        v[`CRC_CC_INT_FAST_RDY] = st_reg.int_fast_on;
        v[`CRC_CC_EXT_FAST_ON] = st_reg.ext_fast_on;
        v[`CRC_CC_EXT_FAST_RDY] = ext_fast_rdy;
        v[`CRC_CC_EXT_FAST_BYP] = st_reg.ext_fast_byp;
        v[`CRC_CC_PLL_ON] = st_reg.pll_on;
        v[`CRC_CC_PLL_RDY] = pll_rdy;
      end
      `CRC_OFS_CLK_CFG: begin
        v[`CRC_CFG_REQ_LSB +: 2] = st_reg.req;
        v[`CRC_CFG_ACT_LSB +: 2] = st_reg.act;
      end
      `CRC_OFS_BACKUP: begin
        v[`CRC_BD_SLOW_ON] = st_reg.slow_on;
        v[`CRC_BD_SLOW_RDY] = ext_slow_rdy;
        v[`CRC_BD_RTC_SEL_LSB +: 2] = st_reg.rtc_sel;
        v[`CRC_BD_WDG_SEL] = st_reg.wdg_sel;
        v[`CRC_BD_SWRST] = st_reg.bd_swrst;
      end
      `CRC_OFS_RST_CAUSE: begin
        v[`CRC_RC_PIN] = st_reg.f_pin;
        v[`CRC_RC_POR] = st_reg.f_por;
        v[`CRC_RC_SW] = st_reg.f_sw;
        v[`CRC_RC_INDEPENDENT_WATCHDOG] = st_reg.f_independent_watchdog;
        v[`CRC_RC_WINDOW_WATCHDOG] = st_reg.f_window_watchdog;
        v[`CRC_RC_LP] = st_reg.f_lp;
      end
      `CRC_OFS_PWR_CTRL: begin
        v[`CRC_PC_UNLOCK] = st_reg.unlock;
      end
      default: begin
        v = 32'h0000_0000;
      end
    endcase
    return v;
  endfunction

  function automatic logic [31:0] crc_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] m;
    m = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // Source feeds the system clock directly or as the PLL reference
  function automatic logic crc_in_use(input crc_src_t s);
    return st_reg.act == s || (st_reg.act == CRC_SRC_PLL && s == CRC_SRC_EXT_FAST);
  endfunction

  function automatic logic crc_ready(input crc_src_t s);
    logic rdy;
    unique case (s)
      CRC_SRC_INT_FAST: rdy = st_reg.int_fast_on;
      CRC_SRC_EXT_FAST: rdy = ext_fast_rdy;
      CRC_SRC_PLL: rdy = pll_rdy;
      CRC_SRC_FABRIC: rdy = 1'b1;
    endcase
    return rdy;
  endfunction

  // ****************************************
  // Oscillator gating and dividers
  // ****************************************
  // withhold external fast
  crc_ready_gate #(.STARTUP(EXT_FAST_STARTUP)) u_ext_fast_gate (
    .core_clk(core_clk),
    .srst(srst),
    .osc_on(ext_fast_osc_en),
    .bypass(st_reg.ext_fast_byp),
    .src_tick(ext_fast_tick),
    .ready(ext_fast_rdy),
    .gated_tick(ext_fast_gated)
  );

  crc_ready_gate #(.STARTUP(EXT_SLOW_STARTUP)) u_ext_slow_gate (
    .core_clk(core_clk),
    .srst(srst),
    .osc_on(st_reg.slow_on),
    .bypass(1'b0),
    .src_tick(ext_slow_tick),
    .ready(ext_slow_rdy),
    .gated_tick(ext_slow_gated)
  );

  assign int_fast_gated = int_fast_tick & int_fast_osc_en;

  crc_tick_div #(.DIV(`CRC_SLOW_DIV)) u_slow_div (
    .core_clk(core_clk),
    .srst(srst),
    .in_tick(int_fast_gated),
    .out_tick(internal_slow_clk)
  );

  assign pll_rdy = st_reg.pll_on && pll_lock && ext_fast_rdy;

  // ****************************************
  // Reset event decode
  // ****************************************
  // standby or stop entry becomes reset when its option is clear
  assign lp_rst = (standby_entry_req && !standby_reset_option) ||
                  (stop_entry_req && !stop_reset_option);
  assign pwr_evt = power_detect || standby_exit;
  assign sys_evt = !external_reset_pin_n || window_watchdog_expired ||
                   independent_watchdog_expired || core_reset_request || lp_rst || pwr_evt;
  assign bd_evt = backup_supply_up || st_reg.bd_swrst;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [31:0] wd;
    wd = crc_merge(crc_read(st_reg.awaddr), st_reg.wdata, st_reg.wstrb);
    st_next = st_reg;
    st_next.stop_enter = stop_entry_req && stop_reset_option;
    st_next.standby_enter = standby_entry_req && standby_reset_option;

    // Bus handshakes: one write and one read in flight
    if (axil_req.awvalid && axil_rsp.awready) begin
      st_next.aw_got = 1'b1;
      st_next.awaddr = axil_req.awaddr;
    end
    if (axil_req.wvalid && axil_rsp.wready) begin
      st_next.w_got = 1'b1;
      st_next.wdata = axil_req.wdata;
      st_next.wstrb = axil_req.wstrb;
    end
    if (st_reg.bvalid && axil_req.bready) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.rvalid && axil_req.rready) begin
      st_next.rvalid = 1'b0;
    end
    if (axil_req.arvalid && axil_rsp.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rdata = crc_read(axil_req.araddr);
      st_next.rresp = crc_mapped(axil_req.araddr) ? `CRC_RESP_OKAY : `CRC_RESP_SLVERR;
    end

    // Register writes once address and data are both held
    if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = crc_mapped(st_reg.awaddr) ? `CRC_RESP_OKAY : `CRC_RESP_SLVERR;
      unique case (st_reg.awaddr)
        `CRC_OFS_CLK_CTRL: begin
          st_next.int_fast_on = wd[`CRC_CC_INT_FAST_ON] | crc_in_use(CRC_SRC_INT_FAST);
          st_next.ext_fast_on = wd[`CRC_CC_EXT_FAST_ON] | crc_in_use(CRC_SRC_EXT_FAST);
          st_next.pll_on = wd[`CRC_CC_PLL_ON] | crc_in_use(CRC_SRC_PLL);
          if (!st_reg.ext_fast_on) begin
            st_next.ext_fast_byp = wd[`CRC_CC_EXT_FAST_BYP];
          end
        end
        `CRC_OFS_CLK_CFG: begin
          st_next.req = crc_src_t'(wd[`CRC_CFG_REQ_LSB +: 2]);
        end
        `CRC_OFS_BACKUP: begin
          if (st_reg.unlock) begin
            st_next.slow_on = wd[`CRC_BD_SLOW_ON];
            st_next.wdg_sel = wd[`CRC_BD_WDG_SEL];
            st_next.bd_swrst = wd[`CRC_BD_SWRST];
            if (!st_reg.rtc_locked) begin
              st_next.rtc_sel = wd[`CRC_BD_RTC_SEL_LSB +: 2];
              st_next.rtc_locked = wd[`CRC_BD_RTC_SEL_LSB +: 2] != `CRC_RTC_NONE;
            end
          end
        end
        `CRC_OFS_RST_CAUSE: begin
          if (wd[`CRC_RC_CLEAR]) begin
            st_next.f_pin = 1'b0;
            st_next.f_por = 1'b0;
            st_next.f_sw = 1'b0;
            st_next.f_independent_watchdog = 1'b0;
            st_next.f_window_watchdog = 1'b0;
            st_next.f_lp = 1'b0;
          end
        end
        `CRC_OFS_PWR_CTRL: begin
          st_next.unlock = wd[`CRC_PC_UNLOCK];
        end
        default: begin
          st_next.bresp = `CRC_RESP_SLVERR;
        end
      endcase
    end

    unique case (st_reg.sw_st)
      CRC_SW_RUN: begin
        if (st_reg.req != st_reg.act && crc_ready(st_reg.req)) begin
          st_next.sw_st = CRC_SW_GAP;
        end
      end
      CRC_SW_GAP: begin
        st_next.sw_st = CRC_SW_RUN;
        if (crc_ready(st_reg.req)) begin
          st_next.act = st_reg.req;
        end
      end
    endcase

    if (sys_evt || in_standby) begin
      st_next.int_fast_on = 1'b1;
      st_next.ext_fast_on = 1'b0;
      st_next.ext_fast_byp = 1'b0;
      st_next.pll_on = 1'b0;
      st_next.req = CRC_SRC_INT_FAST;
      st_next.act = CRC_SRC_INT_FAST;
      st_next.sw_st = CRC_SW_RUN;
      st_next.unlock = 1'b0;
    end

    if (!external_reset_pin_n) begin
      st_next.f_pin = 1'b1;
    end
    if (window_watchdog_expired) begin
      st_next.f_window_watchdog = 1'b1;
    end
    if (independent_watchdog_expired) begin
      st_next.f_independent_watchdog = 1'b1;
    end
    if (core_reset_request) begin
      st_next.f_sw = 1'b1;
    end
    if (lp_rst) begin
      st_next.f_lp = 1'b1;
    end
    if (pwr_evt) begin
      st_next.f_por = 1'b1;
    end

    if (bd_evt) begin
      st_next.slow_on = 1'b0;
      st_next.rtc_sel = `CRC_RTC_NONE;
      st_next.rtc_locked = 1'b0;
      st_next.wdg_sel = 1'b0;
    end
    if (backup_supply_up) begin
      st_next.bd_swrst = 1'b0;
    end

    // Reset pulses stretched so a one-cycle cause still resets everyone
    st_next.sys_cnt = sys_evt ? 5'(`CRC_RST_PULSE_CYC) :
                      (st_reg.sys_cnt != 5'h00 ? st_reg.sys_cnt - 5'h01 : 5'h00);
    st_next.pwr_cnt = pwr_evt ? 5'(`CRC_RST_PULSE_CYC) :
                      (st_reg.pwr_cnt != 5'h00 ? st_reg.pwr_cnt - 5'h01 : 5'h00);
    st_next.bd_cnt = bd_evt ? 5'(`CRC_RST_PULSE_CYC) :
                     (st_reg.bd_cnt != 5'h00 ? st_reg.bd_cnt - 5'h01 : 5'h00);
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg <= '0;
      st_reg.int_fast_on <= 1'b1;
      st_reg.f_por <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign axil_rsp.awready = !st_reg.aw_got && !st_reg.bvalid;
  assign axil_rsp.wready = !st_reg.w_got && !st_reg.bvalid;
  assign axil_rsp.bvalid = st_reg.bvalid;
  assign axil_rsp.bresp = st_reg.bresp;
  assign axil_rsp.arready = !st_reg.rvalid;
  assign axil_rsp.rvalid = st_reg.rvalid;
  assign axil_rsp.rdata = st_reg.rdata;
  assign axil_rsp.rresp = st_reg.rresp;

  assign clocks_halted = in_stop || in_standby;

  assign int_fast_osc_en = !in_standby && (st_reg.int_fast_on || in_stop);
  assign ext_fast_osc_en = st_reg.ext_fast_on && !clocks_halted;
  assign ext_fast_bypass_en = st_reg.ext_fast_byp && st_reg.ext_fast_on;
  assign pll_en = st_reg.pll_on && !clocks_halted;
  assign ext_slow_osc_en = st_reg.slow_on;

  always_comb begin
    system_clock_out = 1'b0;
    if (st_reg.sw_st == CRC_SW_RUN && !clocks_halted) begin
      unique case (st_reg.act)
        CRC_SRC_INT_FAST: system_clock_out = int_fast_gated;
        CRC_SRC_EXT_FAST: system_clock_out = ext_fast_gated;
        CRC_SRC_PLL: system_clock_out = pll_tick && pll_rdy;
        CRC_SRC_FABRIC: system_clock_out = fabric_local_clock;
      endcase
    end
  end

  always_comb begin
    unique case (st_reg.rtc_sel)
      `CRC_RTC_EXT_SLOW: rtc_clock_out = ext_slow_gated;
      `CRC_RTC_INT_SLOW: rtc_clock_out = internal_slow_clk;
      `CRC_RTC_FABRIC: rtc_clock_out = fabric_local_clock;
      default: rtc_clock_out = 1'b0;
    endcase
  end

  assign watchdog_clock_out = (in_standby || st_reg.wdg_sel) ? ext_slow_gated
                                                             : internal_slow_clk;

  assign sys_reset_out = st_reg.sys_cnt != 5'h00;
  assign power_reset_out = st_reg.pwr_cnt != 5'h00;
  assign backup_reset_out = st_reg.bd_cnt != 5'h00;
  assign stop_enter = st_reg.stop_enter;
  assign standby_enter = st_reg.standby_enter;

endmodule

`default_nettype wire

/* rtl/crc_cfg.svh */
// Offsets, field positions, RTC codes, bus responses and timing counts of the clock and reset controller.
// Assumes a 250 MHz core_clk and a 32-bit AXI4-Lite register port.
`ifndef CRC_CFG_SVH
`define CRC_CFG_SVH

// ****************************************
// Timing
// ****************************************
`define CRC_CLK_PERIOD_NS 4
`define CRC_RST_PULSE_NS 64
`define CRC_RST_PULSE_CYC ((`CRC_RST_PULSE_NS + `CRC_CLK_PERIOD_NS - 1) / `CRC_CLK_PERIOD_NS)
`define CRC_SLOW_DIV 9'h100
`define CRC_EXT_FAST_STARTUP 13'h0800
`define CRC_EXT_SLOW_STARTUP 13'h1000
`define CRC_BYPASS_MAX_MHZ 100

// ****************************************
// Register offsets
// ****************************************
`define CRC_OFS_CLK_CTRL 8'h00
`define CRC_OFS_CLK_CFG 8'h04
`define CRC_OFS_BACKUP 8'h08
`define CRC_OFS_RST_CAUSE 8'h0C
`define CRC_OFS_PWR_CTRL 8'h10

// ****************************************
// Field positions
// ****************************************
`define CRC_CC_INT_FAST_ON 0
`define CRC_CC_INT_FAST_RDY 1
`define CRC_CC_EXT_FAST_ON 16
`define CRC_CC_EXT_FAST_RDY 17
`define CRC_CC_EXT_FAST_BYP 18
`define CRC_CC_PLL_ON 24
`define CRC_CC_PLL_RDY 25
`define CRC_CFG_REQ_LSB 0
`define CRC_CFG_ACT_LSB 2
`define CRC_BD_SLOW_ON 0
`define CRC_BD_SLOW_RDY 1
`define CRC_BD_RTC_SEL_LSB 8
`define CRC_BD_WDG_SEL 10
`define CRC_BD_SWRST 16
`define CRC_RC_CLEAR 24
`define CRC_RC_PIN 26
`define CRC_RC_POR 27
`define CRC_RC_SW 28
`define CRC_RC_INDEPENDENT_WATCHDOG 29
`define CRC_RC_WINDOW_WATCHDOG 30
`define CRC_RC_LP 31
`define CRC_PC_UNLOCK 0

// ****************************************
// RTC source codes and bus responses
// ****************************************
`define CRC_RTC_NONE 2'h0
`define CRC_RTC_EXT_SLOW 2'h1
`define CRC_RTC_INT_SLOW 2'h2
`define CRC_RTC_FABRIC 2'h3
`define CRC_RESP_OKAY 2'h0
`define CRC_RESP_SLVERR 2'h2

`endif

/* rtl/crc_pkg.sv */
// Types shared by the clock and reset controller modules.
// Assumes the AXI4-Lite master drives only the low 8 address bits.
`default_nettype none

package crc_pkg;

  // ****************************************
  // Encodings
  // ****************************************
  typedef enum logic [1:0] {
    CRC_SRC_INT_FAST,
    CRC_SRC_EXT_FAST,
    CRC_SRC_PLL,
    CRC_SRC_FABRIC
  } crc_src_t;

  typedef enum logic {
    CRC_SW_RUN,
    CRC_SW_GAP
  } crc_sw_state_t;

  // ****************************************
  // Bus carriers
  // ****************************************
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } crc_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } crc_axil_rsp_t;

  // ****************************************
  // Module state
  // ****************************************
  typedef struct packed {
    logic [12:0] count;
    logic ready;
  } crc_gate_st_t;

  typedef struct packed {
    logic [7:0] count;
  } crc_div_st_t;

  typedef struct packed {
    logic int_fast_on;
    logic ext_fast_on;
    logic ext_fast_byp;
    logic pll_on;
    crc_src_t req;
    crc_src_t act;
    crc_sw_state_t sw_st;
    logic slow_on;
    logic [1:0] rtc_sel;
    logic rtc_locked;
    logic wdg_sel;
    logic bd_swrst;
    logic unlock;
    logic f_pin;
    logic f_por;
    logic f_sw;
    logic f_independent_watchdog;
    logic f_window_watchdog;
    logic f_lp;
    logic [4:0] sys_cnt;
    logic [4:0] pwr_cnt;
    logic [4:0] bd_cnt;
    logic stop_enter;
    logic standby_enter;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } crc_top_st_t;

endpackage

`default_nettype wire

/* rtl/crc_ready_gate.sv */
// Oscillator start-up gate: counts source ticks after switch-on, then flags ready.
// Assumes src_tick is a one-cycle enable pulse per oscillator period.
`timescale 1ns/1ns
`default_nettype none
`include "crc_cfg.svh"

module crc_ready_gate #(
  parameter logic [12:0] STARTUP = `CRC_EXT_FAST_STARTUP
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Oscillator
  input wire logic osc_on,
  input wire logic bypass,
  input wire logic src_tick,
  // Gated result
  output logic ready,
  output logic gated_tick
);
  import crc_pkg::*;

  crc_gate_st_t st_reg;
  crc_gate_st_t st_next;

  always_comb begin
    st_next = st_reg;
    if (!osc_on) begin
      st_next = '0;
    end else if (!st_reg.ready) begin
      // An external clock in bypass needs no resonator settling
      if (bypass) begin
        st_next.ready = 1'b1;
      end else if (src_tick) begin
        st_next.count = st_reg.count + 13'h1;
        if (st_reg.count == STARTUP - 13'h1) begin
          st_next.ready = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign ready = st_reg.ready;
  assign gated_tick = src_tick & st_reg.ready;

endmodule

`default_nettype wire

/* rtl/crc_tick_div.sv */
// Tick divider: one output pulse for every DIV input ticks.
// Assumes in_tick is a one-cycle enable pulse.
`timescale 1ns/1ns
`default_nettype none
`include "crc_cfg.svh"

module crc_tick_div #(
  parameter logic [8:0] DIV = `CRC_SLOW_DIV
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Ticks
  input wire logic in_tick,
  output logic out_tick
);
  import crc_pkg::*;

  crc_div_st_t st_reg;
  crc_div_st_t st_next;
  logic wrap;

  assign wrap = ({1'b0, st_reg.count} == DIV - 9'h1);

  always_comb begin
    st_next = st_reg;
    if (in_tick) begin
      st_next.count = wrap ? 8'h00 : st_reg.count + 8'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign out_tick = in_tick & wrap;

endmodule

`default_nettype wire

/* test/crc_osc_model.sv */
// Oscillator and PLL stand-in for the far side of crc_top.
// Enables come from crc_top; each tick is a one-cycle pulse.
`timescale 1ns/1ns
`default_nettype none
module crc_osc_model (
  // Clock, reset, enables: int fast, ext fast, pll, ext slow
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [3:0] en,
  // Ticks in enable order, then pll lock, then fabric tick
  output logic [5:0] tk
);
  logic [7:0] cnt;
  logic [3:0] lk;
  always_ff @(posedge core_clk) begin
    cnt <= srst ? 8'h00 : cnt + 8'h01;
    lk <= en[2] ? lk + {3'h0, ~&lk} : 4'h0;
  end
  // Sparse external ticks keep start-up waits visible
  assign tk = {cnt[1:0] == 2'h1, &lk, en & {cnt[3:0] == 4'hF, cnt[0], cnt[2:0] == 3'h7, cnt[0]}};
endmodule
`default_nettype wire

/* test/crc_top_asserts.sv */
// Checker on crc_top reset and stop ports.
// Bound to crc_top; srst is synchronous, active high.
`timescale 1ns/1ns
`default_nettype none
module crc_top_asserts (
  // Watched ports
  input wire logic core_clk,
  input wire logic srst,
  input wire logic external_reset_pin_n,
  input wire logic core_reset_request,
  input wire logic stop_entry_req,
  input wire logic stop_reset_option,
  input wire logic standby_exit,
  input wire logic backup_supply_up,
  input wire logic stop_enter,
  input wire logic sys_reset_out,
  input wire logic power_reset_out,
  input wire logic backup_reset_out,
  // Watched clock and standby ports
  input wire logic int_fast_tick,
  input wire logic int_fast_osc_en,
  input wire logic internal_slow_clk,
  input wire logic system_clock_out,
  input wire logic standby_entry_req,
  input wire logic standby_reset_option,
  input wire logic standby_enter
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // Own count of gated fast ticks, wraps every 256
  logic [7:0] slow_cnt;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      slow_cnt <= 8'h00;
    end else if (int_fast_tick && int_fast_osc_en) begin
      slow_cnt <= slow_cnt + 8'h01;
    end
  end
  property p_sw; core_reset_request |=> sys_reset_out [*8]; endproperty
  a_sw: assert property (p_sw) else $error("sw reset short");
  property p_pin; !external_reset_pin_n |=> sys_reset_out [*8]; endproperty
  a_pin: assert property (p_pin) else $error("pin reset short");
  property p_stp; stop_entry_req && !stop_reset_option |=> sys_reset_out; endproperty
  a_stp: assert property (p_stp) else $error("stop reset missing");
  property p_ste; stop_entry_req && stop_reset_option |=> stop_enter; endproperty
  a_ste: assert property (p_ste) else $error("stop entry missing");
  property p_ope; stop_enter |-> $past(stop_reset_option); endproperty
  a_ope: assert property (p_ope) else $error("stop entered");
  property p_pwr; standby_exit |=> power_reset_out [*8]; endproperty
  a_pwr: assert property (p_pwr) else $error("power reset short");
  property p_hi; power_reset_out |-> sys_reset_out; endproperty
  a_hi: assert property (p_hi) else $error("power without system reset");
  property p_bkp; backup_supply_up |=> backup_reset_out [*8]; endproperty
  a_bkp: assert property (p_bkp) else $error("backup reset short");
  property p_stb; standby_entry_req && standby_reset_option |=> standby_enter; endproperty
  a_stb: assert property (p_stb) else $error("standby entry missing");
  property p_dflt;
    $rose(sys_reset_out) |-> system_clock_out == (int_fast_tick && int_fast_osc_en);
  endproperty
  a_dflt: assert property (p_dflt) else $error("reset source not internal fast");
  property p_div;
    internal_slow_clk == (int_fast_tick && int_fast_osc_en && slow_cnt == 8'hFF);
  endproperty
  a_div: assert property (p_div) else $error("slow clock ratio wrong");
endmodule
`default_nettype wire

/* test/crc_top_tb.sv */
// Bench for crc_top: register bus, clock switch, backup lock, reset causes.
// Needs crc_osc_model and crc_top_asserts compiled ahead of it.
`timescale 1ns/1ns
`default_nettype none
module crc_top_tb;
  import crc_pkg::*;
  logic core_clk = 1'b0, srst = 1'b1, opt = 1'b1;
  logic [8:0] ev = 9'h000;
  wire [3:0] en;
  wire [5:0] tk;
  // Ready lines stay high, so no response is ever stalled
  crc_axil_req_t req = '{bready: 1'b1, rready: 1'b1, wstrb: 4'hF, default: '0};
  crc_axil_rsp_t rsp;
  logic [33:0] exq[$];
  int n_mismatch = 0, compares = 0;
  integer seed = 32'haac6;
  int fb[8] = '{26, 30, 29, 28, 31, 31, 27, 27};
  crc_top #(.EXT_FAST_STARTUP(13'h0004), .EXT_SLOW_STARTUP(13'h0004)) u_dut (
    .core_clk, .srst, .axil_req(req), .axil_rsp(rsp), .int_fast_tick(tk[0]),
    .ext_fast_tick(tk[1]), .pll_tick(tk[2]), .pll_lock(tk[4]), .fabric_local_clock(tk[5]),
    .ext_slow_tick(tk[3]), .int_fast_osc_en(en[0]), .ext_fast_osc_en(en[1]), .pll_en(en[2]),
    .ext_slow_osc_en(en[3]), .ext_fast_bypass_en(), .system_clock_out(), .rtc_clock_out(),
    .watchdog_clock_out(), .internal_slow_clk(), .external_reset_pin_n(!ev[0]),
    .window_watchdog_expired(ev[1]), .independent_watchdog_expired(ev[2]),
    .core_reset_request(ev[3]), .stop_entry_req(ev[4]), .standby_entry_req(ev[5]),
    .standby_reset_option(opt), .stop_reset_option(opt), .power_detect(ev[6]),
    .standby_exit(ev[7]), .backup_supply_up(ev[8]), .in_stop(1'b0), .in_standby(1'b0),
    .sys_reset_out(), .power_reset_out(), .backup_reset_out(), .stop_enter(), .standby_enter());
  crc_osc_model u_osc (.core_clk, .srst, .en, .tk);
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e);
    logic ta, tw, tr, td;
    td = 1'b0;
    if (!w) exq.push_back(e);
    req.awaddr <= a;
    req.araddr <= a;
    req.wdata <= d;
    req.awvalid <= w;
    req.wvalid <= w;
    req.arvalid <= !w;
    while (!td) begin
      @(negedge core_clk);
      ta = req.awvalid && rsp.awready;
      tw = req.wvalid && rsp.wready;
      tr = req.arvalid && rsp.arready;
      td = w ? rsp.bvalid : rsp.rvalid;
      @(posedge core_clk);
      if (ta) req.awvalid <= 1'b0;
      if (tw) req.wvalid <= 1'b0;
      if (tr) req.arvalid <= 1'b0;
    end
  endtask
  task automatic chk(input logic [33:0] e, input logic [33:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR read resp_data expected %h seen %h", e, g);
    end
  endtask
  always @(negedge core_clk) begin
    if (rsp.rvalid && exq.size() > 0) begin
      chk(exq.pop_front(), {rsp.rresp, rsp.rdata});
    end
  end
  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    @(posedge core_clk);
    ev[i] <= 1'b0;
    repeat (24) @(posedge core_clk);
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    xfer(0, 8'h00, 0, 34'h3);
    xfer(0, {1'b1, 5'($random(seed)), 2'h0}, 0, 34'h2_0000_0000);
    xfer(1, 8'h00, 32'h0001_0001, 0);
    xfer(1, 8'h04, 32'h1, 0);
    xfer(0, 8'h04, 0, 34'h1);
    repeat (60) @(posedge core_clk);
    xfer(0, 8'h04, 0, 34'h5);
    xfer(1, 8'h00, 32'h1, 0);
    xfer(0, 8'h00, 0, 34'h0003_0003);
    xfer(1, 8'h08, $random(seed), 0);
    xfer(0, 8'h08, 0, 34'h0);
    xfer(1, 8'h10, 32'h1, 0);
    xfer(1, 8'h08, 32'h200, 0);
    xfer(1, 8'h08, 32'h100, 0);
    xfer(0, 8'h08, 0, 34'h200);
    $display("test done: clock select and backup lock");
    opt <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      xfer(1, 8'h0C, 32'h0100_0000, 0);
      pulse(i);
      xfer(0, 8'h0C, 0, {2'h0, 32'h1 << fb[i]});
    end
    opt <= 1'b1;
    pulse(4);
    pulse(5);
    pulse(8);
    repeat (400) @(posedge core_clk);
    $display("test done: reset causes");
    give_verdict();
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    n_mismatch++;
    give_verdict();
  end
endmodule
bind crc_top crc_top_asserts u_chk (.core_clk, .srst, .external_reset_pin_n,
  .core_reset_request, .stop_entry_req, .stop_reset_option, .standby_exit,
  .backup_supply_up, .stop_enter, .sys_reset_out, .power_reset_out, .backup_reset_out,
  .int_fast_tick, .int_fast_osc_en, .internal_slow_clk, .system_clock_out,
  .standby_entry_req, .standby_reset_option, .standby_enter);
`default_nettype wire
